// *** hw/slot_hp_pkg.sv ***
package slot_hp_pkg;
    // Dword-aligned configuration byte addresses of the slot registers
    localparam logic [11:0] CAP_OFS = 12'h00D4;
    localparam logic [11:0] CTL_OFS = 12'h00D8;
    // Implemented and writable bits of the slot capabilities register
    localparam logic [31:0] CAP_IMPL = 32'hFFF9_FFFB;
    localparam logic [31:0] CAP_WR = 32'h0001_FF80;
    localparam logic [31:0] CAP_RST = 32'h0000_0000;
    localparam int PLIM_LSB = 7;
    localparam int PLIM_W = 10;
    // Implemented bits of slot control and their value after reset
    localparam logic [15:0] CTL_IMPL = 16'h17FB;
    localparam logic [15:0] CTL_RST = 16'h03C0;
    localparam int HPIE_BIT = 5;
    localparam int ATT_LSB = 6;
    localparam int PWI_LSB = 8;
    localparam int PCC_BIT = 10;
    // Indicator encodings
    localparam logic [1:0] IND_ON = 2'h1;
    localparam logic [1:0] IND_BLINK = 2'h2;
    localparam logic [1:0] IND_OFF = 2'h3;
    // Sticky status flags: position in the dword, and their enable bit
    localparam int NSTS = 5;
    localparam int STS_POS [NSTS] = '{16, 17, 19, 20, 24};
    localparam int STS_EN [NSTS] = '{0, 1, 3, 4, 12};

    typedef enum logic [2:0] {
        MSG_SET_PWR_LIMIT,
        MSG_ATT_ON,
        MSG_ATT_BLINK,
        MSG_ATT_OFF,
        MSG_PWR_ON,
        MSG_PWR_BLINK,
        MSG_PWR_OFF
    } msg_kind_t;
endpackage

// *** hw/slot_hotplug_regs.sv ***
`timescale 1ns/1ps
module slot_hotplug_regs
    import slot_hp_pkg::*;
#(
    parameter bit DOWNSTREAM = 1'b1
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic cfg_req,
    input wire logic cfg_we,
    input wire logic [11:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    input wire logic preload_valid,
    input wire logic [31:0] preload_cap,
    input wire logic attn_btn_evt,
    input wire logic pwr_fault_evt,
    input wire logic presence_chg_evt,
    input wire logic cmd_done_evt,
    input wire logic dll_link_active,
    input wire logic msg_ready,
    output logic msg_valid,
    output msg_kind_t msg_kind,
    output logic [PLIM_W-1:0] msg_power_limit,
    output logic [1:0] attn_ind_ctl,
    output logic [1:0] pwr_ind_ctl,
    output logic slot_power_off,
    output logic hp_irq
);
    logic [1:0] rst_sync;
    logic rst_n;
    logic [31:0] cap_q;
    logic [15:0] ctl_q;
    logic [NSTS-1:0] sts_q;
    logic [NSTS-1:0] sts_set;
    logic [NSTS-1:0] sts_clr;
    logic [NSTS-1:0] sts_en;
    logic [31:0] sts_word;
    logic dll_prev;
    logic pend_spl;
    logic pend_att;
    logic pend_pwr;

    // Reset is released through two flops so every flop on rst_n leaves reset together; the two synchronizer flops are released by arst_n
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Address decode; an upstream port answers but exposes nothing here
    wire hit_cap = DOWNSTREAM && cfg_addr[11:2] == CAP_OFS[11:2];
    wire hit_ctl = DOWNSTREAM && cfg_addr[11:2] == CTL_OFS[11:2];
    wire wr_cap = cfg_req && cfg_we && hit_cap;
    wire wr_ctl = cfg_req && cfg_we && hit_ctl;
    wire [31:0] be_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}},
                           {8{cfg_be[1]}}, {8{cfg_be[0]}}};

    // Capabilities take software writes only in the power limit fields, the rest is RO; control in all implemented bits
    wire [31:0] cap_wmask = be_mask & CAP_WR;
    wire [31:0] next_cap = (cap_q & ~cap_wmask) | (cfg_wdata & cap_wmask);
    wire [15:0] ctl_wmask = be_mask[15:0] & CTL_IMPL;
    wire [15:0] next_ctl = (ctl_q & ~ctl_wmask) |
                           (cfg_wdata[15:0] & ctl_wmask);

    // Message triggers, decided by which byte lanes a write touched
    wire spl_write = wr_cap && |cap_wmask;
    wire att_write = wr_ctl && cfg_be[0];
    wire pwr_write = wr_ctl && cfg_be[1];

    // Capabilities: loader preload has the last word over a host write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_q <= CAP_RST;
        end else if (preload_valid) begin
            cap_q <= preload_cap & CAP_IMPL;
        end else if (wr_cap) begin
            cap_q <= next_cap;
        end
    end

    // Slot control; indicators come up off, enables and power bit clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= CTL_RST;
        end else if (wr_ctl) begin
            ctl_q <= next_ctl;
        end
    end

    // Event flags, one per bit; a new event beats a same-cycle clear
    wire dll_change = dll_link_active != dll_prev;
    assign sts_set = {dll_change, cmd_done_evt, presence_chg_evt,
                      pwr_fault_evt, attn_btn_evt};
    genvar gi;
    generate
        for (gi = 0; gi < NSTS; gi++) begin : g_sts
            assign sts_clr[gi] = wr_ctl && cfg_be[STS_POS[gi] / 8]
                                 && cfg_wdata[STS_POS[gi]];
            assign sts_en[gi] = ctl_q[STS_EN[gi]];
            assign sts_word[STS_POS[gi]] = sts_q[gi];
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sts_q[gi] <= 1'b0;
                end else if (sts_set[gi]) begin
                    sts_q[gi] <= 1'b1;
                end else if (sts_clr[gi]) begin
                    sts_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate
    assign sts_word[15:0] = ctl_q & CTL_IMPL;
    assign sts_word[18] = 1'b0;
    assign sts_word[23:21] = 3'h0;
    assign sts_word[31:25] = 7'h00;

    // Link-active history; starts low to match its inactive reset state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dll_prev <= 1'b0;
        end else begin
            dll_prev <= dll_link_active;
        end
    end

    // Read mux; unmapped offsets and upstream ports return zero
    wire [31:0] rd_mux = hit_cap ? (cap_q & CAP_IMPL) :
                         hit_ctl ? sts_word : 32'h0000_0000;

    // Every request is answered one cycle later, reads and writes alike
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ack <= 1'b0;
            cfg_rdata <= 32'h0000_0000;
        end else begin
            cfg_ack <= cfg_req;
            cfg_rdata <= (cfg_req && !cfg_we) ? rd_mux : 32'h0000_0000;
        end
    end

    // Combined hot-plug interrupt, gated by the master enable
    wire irq_cond = ctl_q[HPIE_BIT] && |(sts_q & sts_en);

    // Indicator and power outputs follow the control register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hp_irq <= 1'b0;
            attn_ind_ctl <= IND_OFF;
            pwr_ind_ctl <= IND_OFF;
            slot_power_off <= 1'b0;
        end else begin
            hp_irq <= irq_cond;
            attn_ind_ctl <= ctl_q[ATT_LSB +: 2];
            pwr_ind_ctl <= ctl_q[PWI_LSB +: 2];
            slot_power_off <= ctl_q[PCC_BIT];
        end
    end

    // Message sequencer. One write may ask for two messages, so requests
    // wait as pending flags and go out one at a time, limit first. The
    // payload is sampled at launch, so back-to-back writes send the latest.
    wire launch_ok = !msg_valid || msg_ready;
    wire take_spl = launch_ok && pend_spl;
    wire take_att = launch_ok && !pend_spl && pend_att;
    wire take_pwr = launch_ok && !pend_spl && !pend_att && pend_pwr;
    wire [1:0] att_now = ctl_q[ATT_LSB +: 2];
    wire [1:0] pwr_now = ctl_q[PWI_LSB +: 2];
    // The reserved code 00 has no message and is dropped
    wire send_att = take_att && att_now != 2'h0;
    wire send_pwr = take_pwr && pwr_now != 2'h0;
    wire any_send = take_spl || send_att || send_pwr;
    wire [2:0] att_sel = {1'b0, att_now} + 3'h0;
    wire [2:0] pwr_sel = {1'b0, pwr_now} + 3'h3;
    wire msg_kind_t next_kind = take_spl ? MSG_SET_PWR_LIMIT :
                                send_att ? msg_kind_t'(att_sel) :
                                msg_kind_t'(pwr_sel);

    // Pending flags: a fresh write re-arms even while one is launched
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_spl <= 1'b0;
            pend_att <= 1'b0;
            pend_pwr <= 1'b0;
        end else begin
            pend_spl <= spl_write || (pend_spl && !take_spl);
            pend_att <= att_write || (pend_att && !take_att);
            pend_pwr <= pwr_write || (pend_pwr && !take_pwr);
        end
    end

    // Message port: valid holds until the link accepts it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_valid <= 1'b0;
            msg_kind <= MSG_SET_PWR_LIMIT;
            msg_power_limit <= '0;
        end else if (launch_ok) begin
            msg_valid <= any_send;
            msg_kind <= next_kind;
            msg_power_limit <= cap_q[PLIM_LSB +: PLIM_W];
        end
    end

    // Each request is acknowledged exactly one cycle later
    req_ack_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg_req |=> cfg_ack)
        else $error("Request not acknowledged next cycle");

    // Upstream port or unmapped read returns zero
    rsvd_read_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cfg_req && !cfg_we && !hit_cap && !hit_ctl
        |=> cfg_rdata == 32'h0000_0000)
        else $error("Unmapped read gave nonzero data");

    // Reserved bits of the capability read stay zero
    cap_rsvd_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cfg_req && !cfg_we && hit_cap |=> (cfg_rdata & ~CAP_IMPL) == 0)
        else $error("Reserved capability bit read as one");

    // Interrupt tracks enabled flags under the master enable
    irq_gate_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ##1 hp_irq == $past(ctl_q[HPIE_BIT] && |(sts_q & sts_en)))
        else $error("Interrupt disagrees with flags and enables");

    // A link-active change raises its flag next cycle
    dll_flag_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        dll_link_active != dll_prev |=> sts_q[4])
        else $error("Link change did not set its flag");

    // Writing one clears command-completed when no new event arrives
    cc_clear_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        sts_clr[3] && !cmd_done_evt |=> !sts_q[3])
        else $error("Command-completed flag not cleared");

    // Power limit write leads to its message when no message is outstanding
    spl_msg_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        spl_write && !msg_valid |=> ##[0:1] msg_valid
        && msg_kind == MSG_SET_PWR_LIMIT)
        else $error("Power limit write sent no message");

    // Indicator output mirrors the stored attention field
    att_out_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        wr_ctl && cfg_be[0] |=> ##1 attn_ind_ctl == $past(cfg_wdata[7:6], 2))
        else $error("Attention indicator output wrong");
endmodule

// *** test/slot_link_model.sv ***
`timescale 1ns/1ps
// Link partner: takes hot-plug messages after a programmable stall
module slot_link_model
    import slot_hp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic msg_valid,
    input wire msg_kind_t msg_kind,
    input wire logic [PLIM_W-1:0] msg_power_limit,
    input wire logic [3:0] stall,
    output logic msg_ready
);
    logic [3:0] wait_cnt;
    msg_kind_t kinds[$];
    logic [PLIM_W-1:0] lims[$];
    // Ready only rises after the stall, so the sender must hold its request
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            msg_ready <= 1'b0;
            wait_cnt <= '0;
        end else if (msg_valid && msg_ready) begin
            kinds.push_back(msg_kind);
            lims.push_back(msg_power_limit);
            msg_ready <= 1'b0;
            wait_cnt <= '0;
        end else if (msg_valid) begin
            if (wait_cnt >= stall) msg_ready <= 1'b1;
            else wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

// *** test/slot_hotplug_capability_control_bench.sv ***
`timescale 1ns/1ps
module slot_hotplug_capability_control_bench;
    import slot_hp_pkg::*;
    logic sys_clk = 0, arst_n = 0, req = 0, we = 0, pv = 0, dll = 0;
    logic [11:0] addr = '0;
    logic [3:0] be = '0, evt = '0, stall = '0;
    logic [31:0] wd = '0, pc = '0, rd, en;
    logic ack, mv, mr, poff, irq;
    msg_kind_t mk;
    logic [PLIM_W-1:0] ml;
    logic [1:0] ai, pi;
    int err_total = 0, compares = 0;
    always #5 sys_clk = ~sys_clk;
    slot_hotplug_regs i_dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .cfg_req(req), .cfg_we(we), .cfg_addr(addr), .cfg_be(be),
        .cfg_wdata(wd), .cfg_ack(ack), .cfg_rdata(rd),
        .preload_valid(pv), .preload_cap(pc), .attn_btn_evt(evt[0]),
        .pwr_fault_evt(evt[1]), .presence_chg_evt(evt[2]),
        .cmd_done_evt(evt[3]), .dll_link_active(dll), .msg_ready(mr),
        .msg_valid(mv), .msg_kind(mk), .msg_power_limit(ml),
        .attn_ind_ctl(ai), .pwr_ind_ctl(pi), .slot_power_off(poff),
        .hp_irq(irq));
    slot_link_model i_link (.sys_clk(sys_clk), .arst_n(arst_n),
        .msg_valid(mv), .msg_kind(mk), .msg_power_limit(ml),
        .stall(stall), .msg_ready(mr));
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // One access; the answer is awaited under a bound, not assumed
    task automatic acc(logic w, logic [11:0] a, logic [3:0] b,
                       logic [31:0] d, output logic [31:0] r);
        int k;
        req = 1'b1; we = w; addr = a; be = b; wd = d;
        @(posedge sys_clk);
        @(negedge sys_clk);
        req = 1'b0;
        k = 0;
        while (ack !== 1'b1 && k < 4) begin
            cyc(1);
            k++;
        end
        r = rd;
        if (k == 4) chk("cfg_ack", 0, 1);
    endtask
    task automatic wr(logic [11:0] a, logic [3:0] b, logic [31:0] d);
        logic [31:0] r;
        acc(1'b1, a, b, d, r);
    endtask
    task automatic rdc(string n, logic [11:0] a, logic [31:0] e);
        logic [31:0] r;
        acc(1'b0, a, 4'hF, 32'h0, r);
        chk(n, r, e);
    endtask
    task automatic expm(msg_kind_t k, logic [9:0] l, bit cl);
        int n;
        n = 0;
        while (i_link.kinds.size() == 0 && n < 20) begin
            cyc(1);
            n++;
        end
        if (n == 20) chk("msg_seen", 0, 1);
        else begin
            chk("msg_kind", 32'(i_link.kinds.pop_front()), 32'(k));
            if (cl) chk("msg_limit", 32'(i_link.lims[0]), 32'(l));
            void'(i_link.lims.pop_front());
        end
    endtask
    task automatic results();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog: the sequence needs well under ten microseconds
    initial begin
        #100000;
        err_total++;
        results();
    end
    initial begin
        cyc(2);
        arst_n = 1'b1;
        cyc(4);
        rdc("caps_rst", CAP_OFS, CAP_RST);
        rdc("ctl_rst", CTL_OFS, 32'(CTL_RST));
        chk("outs_rst", {ai, pi, poff, irq}, 6'b111100);
        // Slow partner: the limit message must wait for ready
        stall = 4'h3;
        wr(CAP_OFS, 4'hF, 32'hFFFF_FFFF);
        rdc("caps_wr", CAP_OFS, CAP_WR);
        expm(MSG_SET_PWR_LIMIT, 10'h3FF, 1);
        wr(CAP_OFS, 4'h1, 32'h0);
        rdc("caps_lane0", CAP_OFS, 32'h0001_FF00);
        expm(MSG_SET_PWR_LIMIT, 10'h3FE, 1);
        pv = 1'b1; pc = 32'hFFFF_FFFF;
        cyc(1);
        pv = 1'b0; pc = '0;
        rdc("caps_pre", CAP_OFS, CAP_IMPL);
        pv = 1'b1;
        cyc(1);
        pv = 1'b0;
        cyc(6);
        chk("no_msg", i_link.kinds.size(), 0);
        rdc("unmapped", 12'h0DC, 32'h0);
        // Every indicator code on both fields; 00 is stored but silent
        for (int c = 0; c < 4; c++) begin
            wr(CTL_OFS, 4'h3, 32'((c << 8) | (c << 6)));
            rdc("ind_rd", CTL_OFS, 32'((c << 8) | (c << 6)));
            chk("att_ind", ai, c);
            chk("pwr_ind", pi, c);
            if (c == 0) chk("ind_none", i_link.kinds.size(), 0);
            else begin
                expm(msg_kind_t'(c), 10'h0, 0);
                expm(msg_kind_t'(c + 3), 10'h0, 0);
            end
        end
        wr(CTL_OFS, 4'h3, 32'h0000_FFFF);
        rdc("ctl_all", CTL_OFS, 32'(CTL_IMPL));
        chk("power_off", poff, 1);
        expm(MSG_ATT_OFF, 10'h0, 0);
        expm(MSG_PWR_OFF, 10'h0, 0);
        wr(CTL_OFS, 4'h3, 32'h03C0);
        cyc(2);
        chk("power_on", poff, 0);
        // Each event alone: flag, master gate, interrupt, write-one clear
        stall = 4'h0;
        for (int i = 0; i < NSTS; i++) begin
            en = 32'h03C0 | (32'h1 << STS_EN[i]);
            wr(CTL_OFS, 4'h3, en);
            if (i < 4) evt[i] = 1'b1;
            else dll = ~dll;
            cyc(1);
            evt = '0;
            cyc(3);
            chk("irq_masked", irq, 0);
            rdc("flag_set", CTL_OFS, en | (32'h1 << STS_POS[i]));
            wr(CTL_OFS, 4'h3, en | 32'h20);
            cyc(3);
            chk("irq_on", irq, 1);
            wr(CTL_OFS, 4'hC, 32'h1 << STS_POS[i]);
            cyc(3);
            chk("irq_clr", irq, 0);
            rdc("flag_clr", CTL_OFS, en | 32'h20);
        end
        results();
    end
endmodule
